// ### verilog/gpel_defs.svh
// Offsets, bit positions, reset values and timing counts of the
// general-purpose event logic.
// Assumes it is included by its bare name, by the package and the modules.
`ifndef GPEL_DEFS_SVH
`define GPEL_DEFS_SVH

// Configuration byte offsets; each register is 16 bits wide.
`define GPEL_FLAGS_OFS    8'ha8
`define GPEL_ENABLES_OFS  8'haa
// Only this configuration function reaches the two registers.
`define GPEL_CFG_FUNC     3'h0

// Bit positions shared by the flag and the enable register.
`define GPEL_BIT_VID0     15
`define GPEL_BIT_VID1     14
`define GPEL_BIT_PWR      11
`define GPEL_BIT_VPP12    8
`define GPEL_NUM_GPI      5

// Implemented bits; every other bit is reserved and reads zero.
`define GPEL_REG_MASK     16'hc91f
`define GPEL_FLAGS_RST    16'h0000
`define GPEL_ENABLES_RST  16'h0000

// Width of one supply setting field of a socket.
`define GPEL_PWR_W        4
// Clock edges after reset release before change detection is trusted.
`define GPEL_ARM_CYCLES   2'h3

`endif

// ### verilog/gpel_pkg.sv
// Types of the general-purpose event logic.
// Assumes gpel_defs.svh is on the include path.
`include "gpel_defs.svh"

package gpel_pkg;

	// One configuration access from the bus interface, valid for one cycle.
	typedef struct packed {
		logic        req;    // Access strobe, one cycle.
		logic        we;     // High for a write, low for a read.
		logic [2:0]  func;   // Configuration function number.
		logic [7:0]  addr;   // Byte offset in configuration space.
		logic [1:0]  be;     // Byte enables, bit 1 for the upper byte.
		logic [15:0] wdata;  // Write data.
	} gpel_cfg_req_t;

	// Power settings of one socket as software last programmed them.
	typedef struct packed {
		logic [`GPEL_PWR_W-1:0] vcc;     // Supply voltage setting.
		logic [`GPEL_PWR_W-1:0] vpp;     // Programming voltage setting.
		logic                   vpp_12v; // Requested programming level 12 V.
	} gpel_sock_pwr_t;

endpackage

// ### verilog/gpel_sync.sv
// Two-stage synchroniser with a level-change detector for one input pin.
// Assumes the pin is asynchronous to ref_clk_i and may change at any time.
`timescale 1ns/1ps
`include "gpel_defs.svh"

module gpel_sync
(
	input  wire logic ref_clk_i,
	input  wire logic rst_b_i,
	input  wire logic pin_i,
	output logic      level_o,
	output logic      change_o
);

	logic meta_q;  // First stage; only the second stage reads it.
	logic meta_d;  // Next value of the first stage.
	logic sync_q;  // Second stage, safe to use.
	logic sync_d;  // Next value of the second stage.
	logic prev_q;  // Synchronised level one cycle earlier.
	logic prev_d;  // Next value of the previous level.

	// Next values of the chain.
	always_comb
	begin
		meta_d = pin_i;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	// The chain resets to constants; the caller masks the first edges.
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	// Rising and falling transitions both count as a change.
	assign level_o  = sync_q;
	assign change_o = sync_q ^ prev_q;

	// A rise of the synchronised level trails a high first stage by one edge.
	AST_SYNC_DELAY: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(sync_q) |-> $past(meta_q))
		else $error("synchroniser level does not follow first stage");

endmodule // gpel_sync

// ### verilog/gpel_top.sv
// General-purpose event flags and enables with the active-low event output.
// Assumes configuration accesses and socket settings come from logic on
// ref_clk_i, and that the input pins are asynchronous to it.
`timescale 1ns/1ps
`include "gpel_defs.svh"

module gpel_top
	import gpel_pkg::*;
(
	input  wire logic                      ref_clk_i,
	input  wire logic                      rst_b_i,
	input  wire gpel_cfg_req_t             cfg_i,
	input  wire logic [1:0]                video_port_enable_i,
	input  wire gpel_sock_pwr_t [1:0]      sock_pwr_i,
	input  wire logic [`GPEL_NUM_GPI-1:0]  general_input_pin_i,
	input  wire logic [`GPEL_NUM_GPI-1:0]  gpi_mode_sel_i,
	input  wire logic                      event_pin_sel_i,
	output logic [15:0]                    cfg_rdata_o,
	output logic                           cfg_ack_o,
	output logic                           general_event_out_n_o
);

	// Synchronised input levels and their change pulses.
	logic [`GPEL_NUM_GPI-1:0] gpi_level;   // Levels, unused beyond debug.
	logic [`GPEL_NUM_GPI-1:0] gpi_change;  // One-cycle change pulses.

	// Change detection state for the on-chip settings.
	logic [1:0]            arm_q;      // Counts edges after reset.
	logic [1:0]            arm_d;      // Next arm count.
	logic [1:0]            prev_vid_q; // Video enables one cycle ago.
	logic [1:0]            prev_vid_d; // Next previous video enables.
	gpel_sock_pwr_t [1:0]  prev_pwr_q; // Power settings one cycle ago.
	gpel_sock_pwr_t [1:0]  prev_pwr_d; // Next previous power settings.
	logic                  armed;      // Change detection is trusted.

	// Event pulses, one cycle each.
	logic [1:0] vid_evt;   // Video enable changed, per socket.
	logic       pwr_evt;   // A supply setting changed on some socket.
	logic       vpp_evt;   // A 12 V request changed on some socket.
	logic [15:0] set_vec;  // All events placed at their flag positions.

	// Register state.
	logic [15:0] flags_q;   // Sticky event flags.
	logic [15:0] flags_d;   // Next flags.
	logic [15:0] enables_q; // Event enables.
	logic [15:0] enables_d; // Next enables.
	logic [15:0] rdata_q;   // Read data held for the bus.
	logic [15:0] rdata_d;   // Next read data.
	logic        ack_q;     // Access answered.
	logic        ack_d;     // Next answer.
	logic        out_n_q;   // Event output, active low.
	logic        out_n_d;   // Next event output.

	// Access decode.
	logic        hit_func;  // Access is aimed at the owning function.
	logic        hit_flags; // Access hits the flag register.
	logic        hit_en;    // Access hits the enable register.
	logic [15:0] lane_mask; // Write data bits covered by byte enables.
	logic [15:0] clr_vec;   // Flags that software clears this cycle.
	logic [15:0] active;    // Flags that currently request the output.

	// One synchroniser per input pin.
	genvar g;
	generate
		for (g = 0; g < `GPEL_NUM_GPI; g++)
		begin : g_gpi
			gpel_sync u_sync
			(
				.ref_clk_i (ref_clk_i),
				.rst_b_i   (rst_b_i),
				.pin_i     (general_input_pin_i[g]),
				.level_o   (gpi_level[g]),
				.change_o  (gpi_change[g])
			);
		end
	endgenerate

	// Arm counter and previous values for change detection.
	// The synchroniser needs three edges before its previous stage holds a
	// real pin level, so nothing counts as a change before then; the price
	// is that a change in those first cycles is not flagged.
	always_comb
	begin
		arm_d = (arm_q == `GPEL_ARM_CYCLES) ? arm_q : arm_q + 2'h1;
		prev_vid_d = video_port_enable_i;
		prev_pwr_d = sock_pwr_i;
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			arm_q      <= 2'h0;
			prev_vid_q <= 2'h0;
			prev_pwr_q <= '0;
		end
		else
		begin
			arm_q      <= arm_d;
			prev_vid_q <= prev_vid_d;
			prev_pwr_q <= prev_pwr_d;
		end
	end

	assign armed = (arm_q == `GPEL_ARM_CYCLES);

	// Event detection from the current and previous settings.
	always_comb
	begin
		vid_evt = {2{armed}} & (video_port_enable_i ^ prev_vid_q);
		// Any supply field differing on either socket is a power change.
		pwr_evt = armed &
			((sock_pwr_i[0].vcc != prev_pwr_q[0].vcc) |
			 (sock_pwr_i[0].vpp != prev_pwr_q[0].vpp) |
			 (sock_pwr_i[1].vcc != prev_pwr_q[1].vcc) |
			 (sock_pwr_i[1].vpp != prev_pwr_q[1].vpp));
		// Only a move of the 12 V request counts here.
		vpp_evt = armed &
			((sock_pwr_i[0].vpp_12v != prev_pwr_q[0].vpp_12v) |
			 (sock_pwr_i[1].vpp_12v != prev_pwr_q[1].vpp_12v));
		set_vec = 16'h0000;
		set_vec[`GPEL_BIT_VID0] = vid_evt[0];
		set_vec[`GPEL_BIT_VID1] = vid_evt[1];
		set_vec[`GPEL_BIT_PWR] = pwr_evt;
		set_vec[`GPEL_BIT_VPP12] = vpp_evt;
		set_vec[`GPEL_NUM_GPI-1:0] = {`GPEL_NUM_GPI{armed}} & gpi_change;
	end

	// Access decode; other functions see neither register.
	always_comb
	begin
		hit_func  = cfg_i.req & (cfg_i.func == `GPEL_CFG_FUNC);
		// The word offset drops the byte bit, so compare seven bits only.
		hit_flags = hit_func & (cfg_i.addr[7:1] == 7'(`GPEL_FLAGS_OFS >> 1));
		hit_en    = hit_func &
			(cfg_i.addr[7:1] == 7'(`GPEL_ENABLES_OFS >> 1));
		lane_mask = {{8{cfg_i.be[1]}}, {8{cfg_i.be[0]}}};
		clr_vec   = (hit_flags & cfg_i.we) ?
			(cfg_i.wdata & lane_mask) : 16'h0000;
	end

	// Register next values.
	always_comb
	begin
		// A set in the same cycle as a clear wins, so no event is lost; the
		// enables never gate the setting of a flag.
		flags_d = ((flags_q & ~clr_vec) | set_vec) &
			`GPEL_REG_MASK;
		enables_d = enables_q;
		if (hit_en & cfg_i.we)
		begin
			enables_d = ((cfg_i.wdata & lane_mask) |
				(enables_q & ~lane_mask)) & `GPEL_REG_MASK;
		end
		// Unmapped offsets and writes answer with zero data.
		rdata_d = 16'h0000;
		if (hit_flags & ~cfg_i.we)
		begin
			rdata_d = flags_q & `GPEL_REG_MASK;
		end
		else if (hit_en & ~cfg_i.we)
		begin
			rdata_d = enables_q & `GPEL_REG_MASK;
		end
		ack_d = cfg_i.req;
	end

	// Event output request: input enables count only for pins in input mode.
	always_comb
	begin
		active = flags_q & enables_q &
			{{(16-`GPEL_NUM_GPI){1'b1}}, gpi_mode_sel_i};
		// Output stays low while an enabled, counted flag remains and the pin is selected; dropping any of these releases it.
		out_n_d = ~((|active) & event_pin_sel_i);
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			flags_q   <= `GPEL_FLAGS_RST;
			enables_q <= `GPEL_ENABLES_RST;
			rdata_q   <= 16'h0000;
			ack_q     <= 1'b0;
			out_n_q   <= 1'b1;
		end
		else
		begin
			flags_q   <= flags_d;
			enables_q <= enables_d;
			rdata_q   <= rdata_d;
			ack_q     <= ack_d;
			out_n_q   <= out_n_d;
		end
	end

	assign cfg_rdata_o           = rdata_q;
	assign cfg_ack_o             = ack_q;
	assign general_event_out_n_o = out_n_q;

	// Checks on the flags, the bus answer and the event output.
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	AST_VID0_SET: assert property (
		(armed && video_port_enable_i[0] != prev_vid_q[0])
		|=> flags_q[`GPEL_BIT_VID0])
		else $error("socket 0 video change did not set its flag");

	AST_VID1_SET: assert property (
		(armed && $changed(video_port_enable_i[1])) |=> flags_q[`GPEL_BIT_VID1])
		else $error("socket 1 video change did not set its flag");

	AST_PWR_SET: assert property (
		(armed && $past(armed) && $changed(sock_pwr_i[1].vcc))
		|=> flags_q[`GPEL_BIT_PWR])
		else $error("socket supply change did not set the power flag");

	AST_VPP_SET: assert property (
		(armed && $changed(sock_pwr_i[0].vpp_12v)) |=> flags_q[`GPEL_BIT_VPP12])
		else $error("12 V request change did not set its flag");

	AST_GPI_SET: assert property (
		(armed && $past(armed) && $changed(gpi_level[3])) |=> flags_q[3])
		else $error("input pin change did not set its flag");

	AST_CLR_ONE: assert property (
		(hit_flags && cfg_i.we && cfg_i.be[1] && cfg_i.wdata[15] &&
		 !set_vec[15]) |=> !flags_q[15])
		else $error("write of one did not clear the flag");

	AST_KEEP_ZERO: assert property (
		(flags_q[0] && !(clr_vec[0])) |=> flags_q[0])
		else $error("flag dropped without a write of one");

	AST_RESERVED_BITS_ZERO: assert property (
		cfg_ack_o |-> ((cfg_rdata_o & ~`GPEL_REG_MASK) == 16'h0000))
		else $error("reserved bits read nonzero");

	AST_OUT_ASSERT: assert property (
		(flags_q[`GPEL_BIT_PWR] && enables_q[`GPEL_BIT_PWR] && event_pin_sel_i)
		|=> !general_event_out_n_o)
		else $error("enabled flag did not assert the event output");

	AST_OUT_HOLD: assert property (
		(!general_event_out_n_o && !cfg_i.req && !$past(cfg_i.req) &&
		 event_pin_sel_i && $stable(gpi_mode_sel_i))
		|=> !general_event_out_n_o)
		else $error("event output released without a clear");

	AST_NO_PIN: assert property (
		(!event_pin_sel_i) [*2] |-> general_event_out_n_o)
		else $error("event output driven with no pin selected");

	AST_GPI_MODE: assert property (
		(!gpi_mode_sel_i[2] && (active & ~16'h0004) == 16'h0000)
		|=> general_event_out_n_o)
		else $error("input enable counted for a pin not in input mode");

	AST_ACK: assert property (cfg_i.req |=> cfg_ack_o)
		else $error("access not answered in one cycle");

	// The answer and its data stand only in the cycle after an access.
	AST_ACK_IDLE: assert property (
		!cfg_i.req |=> (!cfg_ack_o && cfg_rdata_o == 16'h0000))
		else $error("answer or read data without an access");

	COV_FLAG_CLEAR: cover property (flags_q[15] ##1 hit_flags && cfg_i.we
		##1 !flags_q[15]);
	COV_OUT_LOW: cover property ($fell(general_event_out_n_o));
	COV_SET_CLR: cover property (set_vec[4] && clr_vec[4]);
	COV_EN_READ: cover property (hit_en && !cfg_i.we ##1 cfg_rdata_o != 16'h0);

endmodule // gpel_top

// ### testbench/gpel_top_tb.sv
// Self-checking bench for the general-purpose event logic.
// Assumes the design files and gpel_defs.svh are compiled before it.
`timescale 1ns/1ps
`include "gpel_defs.svh"

module gpel_top_tb
	import gpel_pkg::*;
;
	logic                 ref_clk_i;  // Device clock, 4 ns period.
	logic                 rst_b_i;    // Active-low reset.
	gpel_cfg_req_t        cfg;        // Configuration access.
	logic [1:0]           vid;        // Video-port enables of both sockets.
	gpel_sock_pwr_t [1:0] pwr;        // Power settings of both sockets.
	logic [4:0]           pins;       // Input pin levels.
	logic [4:0]           mode;       // Pins configured as inputs.
	logic                 evsel;      // A pin carries the event output.
	logic [15:0]          rdata;      // Read data from the design.
	logic                 ack;        // Access answer from the design.
	logic                 out_n;      // Active-low event output.
	int                   flags_m;    // Model of the flag register.
	int                   en_m;       // Model of the enable register.
	int                   error_cnt;  // Mismatches seen.
	int                   compares;   // Comparisons made.

	gpel_top gpel_top_inst (
		.ref_clk_i             (ref_clk_i),
		.rst_b_i               (rst_b_i),
		.cfg_i                 (cfg),
		.video_port_enable_i   (vid),
		.sock_pwr_i            (pwr),
		.general_input_pin_i   (pins),
		.gpi_mode_sel_i        (mode),
		.event_pin_sel_i       (evsel),
		.cfg_rdata_o           (rdata),
		.cfg_ack_o             (ack),
		.general_event_out_n_o (out_n)
	);

	// Free-running clock at 250 MHz.
	initial
	begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One comparison; a mismatch is reported and counted at once.
	task automatic chk(input string what, input logic [15:0] seen,
			input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One register access, entered just after a falling edge. The request
	// is held for one rising edge, then the answer is awaited for a few
	// cycles. The model is updated only for function 0 writes.
	task automatic reg_op(input logic we, input logic [2:0] fn,
			input logic [7:0] ad, input logic [1:0] be,
			input logic [15:0] wd);
		int          n;
		logic [15:0] bm;
		logic [15:0] exp;
		bm = {{8{be[1]}}, {8{be[0]}}};
		exp = 16'h0000;
		if (!we && fn == `GPEL_CFG_FUNC && ad[7:1] == 7'h54)
			exp = flags_m[15:0];
		if (!we && fn == `GPEL_CFG_FUNC && ad[7:1] == 7'h55)
			exp = en_m[15:0];
		cfg = '{1'b1, we, fn, ad, be, wd};
		@(negedge ref_clk_i);
		cfg.req = 1'b0;
		n = 0;
		while (ack !== 1'b1 && n < 4)
		begin
			@(negedge ref_clk_i);
			n++;
		end
		chk("access answer", {15'h0000, ack}, 16'h0001);
		chk($sformatf("read data at %h", ad), rdata, exp);
		@(negedge ref_clk_i);
		// The answer is a single-cycle pulse and its data drops with it.
		chk("answer released", {15'h0000, ack}, 16'h0000);
		chk("idle read data", rdata, 16'h0000);
		if (we && fn == `GPEL_CFG_FUNC && ad[7:1] == 7'h54)
			flags_m &= ~int'(wd & bm);
		if (we && fn == `GPEL_CFG_FUNC && ad[7:1] == 7'h55)
			en_m = (en_m & ~int'(bm)) | int'(wd & bm & `GPEL_REG_MASK);
	endtask

	// The output follows flags and enables once things have settled;
	// input enables count only for pins configured as inputs.
	task automatic chk_out();
		int eff;
		repeat (3) @(negedge ref_clk_i);
		eff = en_m & {27'h7ffffff, mode};
		chk("event output", {15'h0000, out_n},
			{15'h0000, !(evsel && (flags_m & eff) != 0)});
	endtask

	// Applies sparse random changes to all event sources at once and
	// records in the model which flags they must set.
	task automatic apply_events();
		logic [1:0]           nv;
		logic [4:0]           np;
		gpel_sock_pwr_t [1:0] npw;
		int                   ev;
		nv = vid ^ 2'($urandom & $urandom);
		np = pins ^ 5'($urandom & $urandom);
		npw = pwr;
		for (int s = 0; s < 2; s++)
		begin
			if ($urandom_range(3) == 0)
				npw[s].vcc = 4'($urandom);
			if ($urandom_range(3) == 0)
				npw[s].vpp = 4'($urandom);
			if ($urandom_range(3) == 0)
				npw[s].vpp_12v = ~pwr[s].vpp_12v;
		end
		ev = int'(np ^ pins);
		ev[15] = nv[0] != vid[0];
		ev[14] = nv[1] != vid[1];
		ev[11] = npw[0].vcc != pwr[0].vcc || npw[0].vpp != pwr[0].vpp
			|| npw[1].vcc != pwr[1].vcc || npw[1].vpp != pwr[1].vpp;
		ev[8] = npw[0].vpp_12v != pwr[0].vpp_12v
			|| npw[1].vpp_12v != pwr[1].vpp_12v;
		vid = nv;
		pins = np;
		pwr = npw;
		flags_m |= ev;
		repeat (8) @(negedge ref_clk_i);
	endtask

	// Watchdog at 200 us; the tests need about 13 us.
	initial
	begin
		#200000;
		error_cnt++;
		report_and_stop();
	end

	// Main sequence: reset, fixed register checks, then random traffic.
	initial
	begin
		void'($urandom(53269));
		rst_b_i = 1'b0;
		cfg = '0;
		vid = 2'h0;
		pwr = '0;
		pins = 5'h00;
		mode = 5'h1f;
		evsel = 1'b1;
		flags_m = 0;
		en_m = 0;
		error_cnt = 0;
		compares = 0;
		repeat (6) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		rst_b_i = 1'b1;
		// Let change detection arm before any source moves.
		repeat (6) @(negedge ref_clk_i);
		reg_op(1'b0, 3'h0, `GPEL_FLAGS_OFS, 2'h3, 16'h0000);
		reg_op(1'b0, 3'h0, `GPEL_ENABLES_OFS, 2'h3, 16'h0000);
		chk_out();
		reg_op(1'b1, 3'h0, `GPEL_ENABLES_OFS, 2'h3, 16'hffff);
		reg_op(1'b0, 3'h0, `GPEL_ENABLES_OFS, 2'h3, 16'h0000);
		reg_op(1'b1, 3'h0, `GPEL_ENABLES_OFS, 2'h1, 16'h0000);
		reg_op(1'b0, 3'h0, `GPEL_ENABLES_OFS, 2'h3, 16'h0000);
		// Other functions and offsets are answered but change nothing.
		reg_op(1'b1, 3'h1, `GPEL_ENABLES_OFS, 2'h3, 16'h0000);
		reg_op(1'b0, 3'h1, `GPEL_ENABLES_OFS, 2'h3, 16'h0000);
		reg_op(1'b0, 3'h0, 8'hac, 2'h3, 16'h0000);
		reg_op(1'b0, 3'h0, `GPEL_ENABLES_OFS, 2'h3, 16'h0000);
		for (int i = 0; i < 150; i++)
		begin
			apply_events();
			mode = 5'($urandom);
			evsel = ($urandom_range(7) != 0);
			reg_op(1'b1, 3'h0, `GPEL_ENABLES_OFS, 2'($urandom),
				16'($urandom));
			chk_out();
			reg_op(1'b0, 3'h0, `GPEL_FLAGS_OFS, 2'h3,
				16'h0000);
			reg_op(1'b1, 3'h0, `GPEL_FLAGS_OFS, 2'($urandom),
				16'($urandom));
			reg_op(1'b0, 3'h0, `GPEL_FLAGS_OFS, 2'h3, 16'h0000);
			chk_out();
		end
		report_and_stop();
	end
endmodule // gpel_top_tb
